// ===== sifu_defines.svh
// Register offsets, field positions, reset values and fill values of the status unit.
// Assumes inclusion by bare name from every file that needs them.
`ifndef SIFU_DEFINES_SVH
`define SIFU_DEFINES_SVH

`define SIFU_OFF_STATUS 8'ha0
`define SIFU_OFF_SEC 8'ha1
`define SIFU_OFF_CLIP 8'ha2
`define SIFU_OFF_LED 8'ha3
`define SIFU_OFF_LIGHT 8'ha5
`define SIFU_OFF_EN1 8'ha8
`define SIFU_OFF_EN2 8'ha9
`define SIFU_OFF_CAUSE1 8'haa
`define SIFU_OFF_CAUSE2 8'hab

`define SIFU_RST_BYTE 8'h00
`define SIFU_SAT_FILL 16'hffff

// Primary status bit positions
`define SIFU_ST_LED 7
`define SIFU_ST_CLIP 6
`define SIFU_ST_FIFO_OVF 5
`define SIFU_ST_FIFO_THR 4
`define SIFU_ST_ADC_THR 3
`define SIFU_ST_LIGHT 2
`define SIFU_ST_SEQ 1
`define SIFU_ST_ADC 0

// Secondary status bit positions
`define SIFU_ST2_HIGH 2
`define SIFU_ST2_LOW 1
`define SIFU_ST2_ECG 0

// Light status bit positions
`define SIFU_LT_CH1_OVER 5
`define SIFU_LT_CH1_UNDER 4
`define SIFU_LT_CH0_OVER 3
`define SIFU_LT_CH0_UNDER 2
`define SIFU_LT_SAT 1
`define SIFU_LT_DONE 0

// Secondary enable bit positions
`define SIFU_EN2_CH1 2
`define SIFU_EN2_CH0 1
`define SIFU_EN2_ECG 0

`endif

// ===== sifu_host_model.sv
// Host side of the interrupt pin: resolves the open-drain line with its pull-up.
// Assumes int_n_i and int_oe_i come straight from the status unit top.
`default_nettype none

module sifu_host_model (
    input wire logic int_n_i,
    input wire logic int_oe_i,
    output logic int_line_o
);
    timeunit 1ns;
    timeprecision 1ns;
    // ----------------------------------------
    // Wired line
    // ----------------------------------------
    assign int_line_o = int_oe_i ? int_n_i : 1'b1;
endmodule

`default_nettype wire

// ===== sifu_pkg.sv
// Types shared by the status unit files.
// Assumes nothing beyond the defines header.
`default_nettype none

package sifu_pkg;
    typedef logic [7:0] sifu_byte_t;
    typedef enum logic [1:0] {
        SIFU_CLR_WRITE_ONE = 2'b01,
        SIFU_CLR_ON_READ = 2'b10
    } sifu_clr_mode_t;
endpackage

`default_nettype wire

// ===== sifu_sticky.sv
// Vector of sticky flags; a set in the same cycle as a clear wins.
// Assumes set and clear come from logic on the same clock.
`default_nettype none

module sifu_sticky
    import sifu_pkg::*;
#(
    parameter int W = 4
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] set_i,
    input wire logic [W-1:0] clr_i,
    output logic [W-1:0] flags_o
);
    generate
        if (W < 1) begin : g_bad
            $error("sifu_sticky width must be at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    flags_o[i] <= 1'b0;
                end else if (set_i[i]) begin
                    flags_o[i] <= 1'b1;
                end else if (clr_i[i]) begin
                    flags_o[i] <= 1'b0;
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ===== sifu_sync.sv
// Two-stage synchroniser for a vector of asynchronous levels.
// Assumes an asynchronous active-low reset from the top.
`default_nettype none

module sifu_sync
    import sifu_pkg::*;
#(
    parameter int W = 8
) (
    input wire logic sys_clk_i,
    input wire logic rst_n_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] sync_o
);
    logic [W-1:0] stage1;

    generate
        if (W < 1) begin : g_bad
            $error("sifu_sync width must be at least one");
        end
    endgenerate

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    stage1[i] <= 1'b0;
                    sync_o[i] <= 1'b0;
                end else begin
                    stage1[i] <= async_i[i];
                    sync_o[i] <= stage1[i];
                end
            end
        end
    endgenerate
endmodule

`default_nettype wire

// ===== sifu_top.sv
// Status and interrupt unit: sticky flags, enable masks, cause registers, interrupt pin.
// Assumes a register port on sys_clk_i and measurement events on the same clock;
// clip and LED supply comparators are asynchronous.
//
// Summary of operation
// - Normal mode: write one clears secondary bit
// - Clear-on-read mode: reading secondary clears all
// - Clip flags: bits 3..0 sticky, read-only
// - LED undervolt flags: one sticky per channel
// - Light bits 5,4: channel one over/under
// - Light bits 3,2: channel zero over/under
// - Saturation sets bit 1, data forced ffff
// - Light bit 0 set on measurement done
// - Primary causes gated by primary enable mask
// - Secondary enables bits 2,1 gate light channels
// - Secondary enable bit 0 gates ECG cause, not flag
// - Cause registers show enabled active flags
// - OR of causes pulls pin low
// - Secondary causes: high, low, ECG
// - Clearing clip/LED flag clears underlying bits
// - FIFO threshold follows level; overflow sticky
// - ECG event polarity selects low or high
`include "sifu_defines.svh"
`default_nettype none

module sifu_top
    import sifu_pkg::*;
#(
    parameter int DATA_W = 16
) (
    input wire logic sys_clk_i,
    input wire logic rstn_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    input wire logic photodiode_clip_low_i,
    input wire logic photodiode_clip_high_i,
    input wire logic second_path_clip_low_i,
    input wire logic second_path_clip_high_i,
    input wire logic [3:0] led_undervolt_i,
    input wire logic light_ch1_over_limit_i,
    input wire logic light_ch1_under_limit_i,
    input wire logic light_ch0_over_limit_i,
    input wire logic light_ch0_under_limit_i,
    input wire logic light_sat_i,
    input wire logic light_done_i,
    input wire logic light_data_valid_i,
    input wire logic [DATA_W-1:0] light_ch0_data_i,
    input wire logic [DATA_W-1:0] light_ch1_data_i,
    output logic [DATA_W-1:0] light_ch0_data_o,
    output logic [DATA_W-1:0] light_ch1_data_o,
    input wire logic adc_done_i,
    input wire logic seq_done_i,
    input wire logic adc_over_thresh_i,
    input wire logic fifo_overflow_i,
    input wire logic fifo_above_thresh_i,
    input wire logic ecg_below_low_i,
    input wire logic ecg_above_high_i,
    input wire logic ecg_polarity_i,
    input wire logic sec_clr_on_read_i,
    output logic int_n_o,
    output logic int_oe_o
);
    // ------------------------------------------------------------
    // Parameter check and reset release
    // ------------------------------------------------------------
    generate
        if (DATA_W != 16) begin : g_bad
            $error("sifu_top data width must be 16");
        end
    endgenerate

    logic rst_meta;
    logic rst_n;

    always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // ------------------------------------------------------------
    // Register access decode
    // ------------------------------------------------------------
    sifu_clr_mode_t clr_mode;
    logic wr_status;
    logic wr_sec;
    logic rd_sec;
    logic wr_en1;
    logic wr_en2;

    assign clr_mode = sec_clr_on_read_i ? SIFU_CLR_ON_READ : SIFU_CLR_WRITE_ONE;
    assign wr_status = reg_wr_i && (reg_addr_i == `SIFU_OFF_STATUS);
    assign wr_sec = reg_wr_i && (reg_addr_i == `SIFU_OFF_SEC);
    assign rd_sec = reg_rd_i && (reg_addr_i == `SIFU_OFF_SEC);
    assign wr_en1 = reg_wr_i && (reg_addr_i == `SIFU_OFF_EN1);
    assign wr_en2 = reg_wr_i && (reg_addr_i == `SIFU_OFF_EN2);

    // ------------------------------------------------------------
    // Clip and LED supply flags
    // ------------------------------------------------------------
    logic [7:0] cmp_async;
    logic [7:0] cmp_sync;
    logic [3:0] clip_flags;
    logic [3:0] led_flags;
    logic [3:0] clip_clr;
    logic [3:0] led_clr;

    assign cmp_async = {led_undervolt_i, photodiode_clip_low_i, photodiode_clip_high_i,
                        second_path_clip_low_i, second_path_clip_high_i};

    sifu_sync #(
        .W(8)
    ) u_cmp_sync (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .async_i(cmp_async),
        .sync_o(cmp_sync)
    );

    assign clip_clr = {4{wr_status && reg_wdata_i[`SIFU_ST_CLIP]}};
    assign led_clr = {4{wr_status && reg_wdata_i[`SIFU_ST_LED]}};

    sifu_sticky #(
        .W(4)
    ) u_clip (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .set_i(cmp_sync[3:0]),
        .clr_i(clip_clr),
        .flags_o(clip_flags)
    );

    sifu_sticky #(
        .W(4)
    ) u_led (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .set_i(cmp_sync[7:4]),
        .clr_i(led_clr),
        .flags_o(led_flags)
    );

    // ------------------------------------------------------------
    // Light measurement flags and data
    // ------------------------------------------------------------
    logic [5:0] light_flags;
    logic [5:0] light_set;
    logic [5:0] light_clr;

    assign light_set = {light_ch1_over_limit_i, light_ch1_under_limit_i,
                        light_ch0_over_limit_i, light_ch0_under_limit_i,
                        light_sat_i,
                        light_done_i};
    assign light_clr = {6{wr_status && reg_wdata_i[`SIFU_ST_LIGHT]}};

    sifu_sticky #(
        .W(6)
    ) u_light (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .set_i(light_set),
        .clr_i(light_clr),
        .flags_o(light_flags)
    );

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            light_ch0_data_o <= '0;
            light_ch1_data_o <= '0;
        end else if (light_sat_i) begin
            light_ch0_data_o <= `SIFU_SAT_FILL;
            light_ch1_data_o <= `SIFU_SAT_FILL;
        end else if (light_data_valid_i) begin
            light_ch0_data_o <= light_ch0_data_i;
            light_ch1_data_o <= light_ch1_data_i;
        end
    end

    // ------------------------------------------------------------
    // Enable masks
    // ------------------------------------------------------------
    sifu_byte_t en1;
    sifu_byte_t en2;

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            en1 <= `SIFU_RST_BYTE;
        end else if (wr_en1) begin
            en1 <= reg_wdata_i;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            en2 <= `SIFU_RST_BYTE;
        end else if (wr_en2) begin
            en2 <= reg_wdata_i;
        end
    end

    // ------------------------------------------------------------
    // Primary status
    // ------------------------------------------------------------
    logic [4:0] prim_set;
    logic [4:0] prim_clr;
    logic [4:0] prim_flags;
    sifu_byte_t status;

    assign prim_set = {fifo_overflow_i, adc_over_thresh_i, light_done_i, seq_done_i, adc_done_i};
    assign prim_clr = {5{wr_status}} & {reg_wdata_i[`SIFU_ST_FIFO_OVF],
                                        reg_wdata_i[`SIFU_ST_ADC_THR],
                                        reg_wdata_i[`SIFU_ST_LIGHT],
                                        reg_wdata_i[`SIFU_ST_SEQ],
                                        reg_wdata_i[`SIFU_ST_ADC]};

    sifu_sticky #(
        .W(5)
    ) u_prim (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .set_i(prim_set),
        .clr_i(prim_clr),
        .flags_o(prim_flags)
    );

    always_comb begin
        status = `SIFU_RST_BYTE;
        status[`SIFU_ST_LED] = |led_flags;
        status[`SIFU_ST_CLIP] = |clip_flags;
        status[`SIFU_ST_FIFO_OVF] = prim_flags[4];
        status[`SIFU_ST_FIFO_THR] = fifo_above_thresh_i;
        status[`SIFU_ST_ADC_THR] = prim_flags[3];
        status[`SIFU_ST_LIGHT] = prim_flags[2];
        status[`SIFU_ST_SEQ] = prim_flags[1];
        status[`SIFU_ST_ADC] = prim_flags[0];
    end

    // ------------------------------------------------------------
    // Secondary status
    // ------------------------------------------------------------
    logic [2:0] sec_set;
    logic [2:0] sec_clr;
    logic [2:0] sec_flags;
    logic ecg_event;

    assign ecg_event = ecg_polarity_i ? ecg_above_high_i : ecg_below_low_i;
    assign sec_set = {(light_ch1_over_limit_i && en2[`SIFU_EN2_CH1]) ||
                      (light_ch0_over_limit_i && en2[`SIFU_EN2_CH0]),
                      (light_ch1_under_limit_i && en2[`SIFU_EN2_CH1]) ||
                      (light_ch0_under_limit_i && en2[`SIFU_EN2_CH0]),
                      ecg_event};
    assign sec_clr = (clr_mode == SIFU_CLR_ON_READ) ? {3{rd_sec}} :
                     ({3{wr_sec}} & reg_wdata_i[2:0]);

    sifu_sticky #(
        .W(3)
    ) u_sec (
        .sys_clk_i(sys_clk_i),
        .rst_n_i(rst_n),
        .set_i(sec_set),
        .clr_i(sec_clr),
        .flags_o(sec_flags)
    );

    // ------------------------------------------------------------
    // Causes and interrupt pin
    // ------------------------------------------------------------
    sifu_byte_t next_cause1;
    sifu_byte_t next_cause2;
    sifu_byte_t cause1;
    sifu_byte_t cause2;
    logic [2:0] en2_eff;

    assign en2_eff = {en2[`SIFU_EN2_CH1] || en2[`SIFU_EN2_CH0],
                      en2[`SIFU_EN2_CH1] || en2[`SIFU_EN2_CH0],
                      en2[`SIFU_EN2_ECG]};
    assign next_cause1 = status & en1;
    assign next_cause2 = {5'h00, sec_flags & en2_eff};

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            cause1 <= `SIFU_RST_BYTE;
            cause2 <= `SIFU_RST_BYTE;
        end else begin
            cause1 <= next_cause1;
            cause2 <= next_cause2;
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            int_n_o <= 1'b0;
            int_oe_o <= 1'b0;
        end else begin
            int_n_o <= 1'b0;
            int_oe_o <= (|next_cause1) || (|next_cause2);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    sifu_byte_t next_rdata;

    always_comb begin
        next_rdata = `SIFU_RST_BYTE;
        case (reg_addr_i)
            `SIFU_OFF_STATUS: next_rdata = status;
            `SIFU_OFF_SEC: next_rdata = {5'h00, sec_flags};
            `SIFU_OFF_CLIP: next_rdata = {4'h0, clip_flags};
            `SIFU_OFF_LED: next_rdata = {4'h0, led_flags};
            `SIFU_OFF_LIGHT: next_rdata = {2'h0, light_flags};
            `SIFU_OFF_EN1: next_rdata = en1;
            `SIFU_OFF_EN2: next_rdata = en2;
            `SIFU_OFF_CAUSE1: next_rdata = cause1;
            `SIFU_OFF_CAUSE2: next_rdata = cause2;
            default: next_rdata = `SIFU_RST_BYTE;
        endcase
    end

    always_ff @(posedge sys_clk_i or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_o <= `SIFU_RST_BYTE;
            reg_rvalid_o <= 1'b0;
        end else begin
            reg_rvalid_o <= reg_rd_i;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_read_sec_cor;
        rd_sec && sec_clr_on_read_i && !(|sec_set);
    endsequence

    sequence s_sec_empty;
        sec_flags == 3'h0;
    endsequence

    chk_w1c_secondary: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        wr_sec && !sec_clr_on_read_i && !reg_rd_i && reg_wdata_i[0] && !sec_set[0]
        |=> !sec_flags[0])
        else $error("secondary bit not cleared by write one");

    chk_w0_keeps_secondary: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        wr_sec && !sec_clr_on_read_i && !reg_wdata_i[2] && sec_flags[2]
        |=> sec_flags[2])
        else $error("secondary bit lost on write zero");

    chk_cor_clears_all: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        s_read_sec_cor |=> s_sec_empty)
        else $error("clear on read left secondary bits");

    chk_clip_sticky: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        cmp_sync[3] && !clip_clr[3] ##1 !cmp_sync[3] && !clip_clr[3] |-> clip_flags[3])
        else $error("clip flag not sticky");

    chk_sat_fill: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        light_sat_i |=> light_ch0_data_o == `SIFU_SAT_FILL && light_ch1_data_o == `SIFU_SAT_FILL
        && light_flags[`SIFU_LT_SAT])
        else $error("saturation did not fill data");

    chk_done_flag: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        light_done_i |=> light_flags[`SIFU_LT_DONE] && status[`SIFU_ST_LIGHT])
        else $error("light done not recorded");

    chk_cause_mask: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        ##1 cause1 == ($past(status) & $past(en1)))
        else $error("primary cause not status and enable");

    chk_pin_follows: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        int_oe_o == ((|cause1) || (|cause2)) && !int_n_o)
        else $error("interrupt pin disagrees with causes");

    chk_led_clear: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        led_clr[0] && !(|cmp_sync[7:4]) |=> led_flags == 4'h0 ##1 !cause1[`SIFU_ST_LED])
        else $error("led flags not cleared via status");

    chk_ecg_polarity: assert property (
        @(posedge sys_clk_i) disable iff (!rst_n)
        ecg_polarity_i && ecg_above_high_i |=> sec_flags[0] [*1] ##1 1'b1)
        else $error("ecg event not recorded");
endmodule

`default_nettype wire

// ===== status_interrupt_unit_tb_top.sv
// Self-checking bench of the status unit: register port, events, interrupt pin.
// Assumes the design files and sifu_host_model are compiled first.
`default_nettype none
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, got, exp); end end

module status_interrupt_unit_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 0, rstn = 0, wr = 0, rd = 0, fthr = 0, pol = 0, cor = 0, dv = 0, rvalid;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [3:0] clip = 4'h0, led = 4'h0;
    logic [11:0] ev = 12'h000;
    logic [15:0] d0i = 16'h0000, d1i = 16'h0000, d0o, d1o;
    logic int_n, int_oe, int_line;
    int error_cnt = 0, tests_run = 0;

    always #50 clk = ~clk;

    sifu_top sifu_top_i (.sys_clk_i(clk), .rstn_i(rstn), .reg_addr_i(addr), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .reg_rvalid_o(rvalid),
        .photodiode_clip_low_i(clip[3]), .photodiode_clip_high_i(clip[2]),
        .second_path_clip_low_i(clip[1]), .second_path_clip_high_i(clip[0]),
        .led_undervolt_i(led), .light_ch1_over_limit_i(ev[5]), .light_ch1_under_limit_i(ev[4]),
        .light_ch0_over_limit_i(ev[3]), .light_ch0_under_limit_i(ev[2]), .light_sat_i(ev[1]),
        .light_done_i(ev[0]), .light_data_valid_i(dv), .light_ch0_data_i(d0i),
        .light_ch1_data_i(d1i), .light_ch0_data_o(d0o), .light_ch1_data_o(d1o),
        .adc_done_i(ev[6]), .seq_done_i(ev[7]), .adc_over_thresh_i(ev[8]),
        .fifo_overflow_i(ev[9]), .fifo_above_thresh_i(fthr), .ecg_below_low_i(ev[10]),
        .ecg_above_high_i(ev[11]), .ecg_polarity_i(pol), .sec_clr_on_read_i(cor),
        .int_n_o(int_n), .int_oe_o(int_oe));

    sifu_host_model sifu_host_model_i (.int_n_i(int_n), .int_oe_i(int_oe),
        .int_line_o(int_line));

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask

    task automatic wreg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk) begin
            wr = 1'b1;
            addr = a;
            wdata = d;
        end
        @(negedge clk) wr = 1'b0;
        tick(1);
    endtask

    task automatic rreg(input logic [7:0] a, input logic [7:0] exp);
        @(negedge clk) begin
            rd = 1'b1;
            addr = a;
        end
        @(negedge clk) rd = 1'b0;
        `CHK(rvalid, 1'b1)
        `CHK(rdata, exp)
    endtask

    task automatic pulse(input logic [11:0] m);
        @(negedge clk) ev = m;
        @(negedge clk) ev = 12'h000;
        tick(1);
    endtask

    task automatic tally_and_finish();
        if (error_cnt == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset();
        logic [7:0] map [10];
        map = '{8'ha0, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha8, 8'ha9, 8'haa, 8'hab};
        foreach (map[i]) rreg(map[i], 8'h00);
        `CHK(int_line, 1'b1)
        wreg(8'ha2, 8'hff);
        rreg(8'ha2, 8'h00);
        wreg(8'ha8, 8'hff);
        rreg(8'ha8, 8'hff);
        rreg(8'haa, 8'h00);
        wreg(8'ha8, 8'h00);
        wreg(8'ha9, 8'h07);
        rreg(8'ha9, 8'h07);
        wreg(8'ha9, 8'h00);
    endtask

    task automatic t_clip_led();
        clip = 4'b1010;
        tick(5);
        clip = 4'h0;
        tick(3);
        rreg(8'ha2, 8'h0a);
        tick(1);
        `CHK(rvalid, 1'b0)
        `CHK(rdata, 8'h0a)
        rreg(8'ha0, 8'h40);
        wreg(8'ha0, 8'h40);
        rreg(8'ha2, 8'h00);
        led = 4'b1001;
        tick(5);
        led = 4'h0;
        tick(3);
        rreg(8'ha3, 8'h09);
        rreg(8'ha0, 8'h80);
        wreg(8'ha0, 8'h80);
        rreg(8'ha3, 8'h00);
        rreg(8'ha0, 8'h00);
    endtask

    task automatic t_light();
        @(negedge clk) begin
            dv = 1'b1;
            d0i = 16'h1234;
            d1i = 16'h5678;
        end
        @(negedge clk) dv = 1'b0;
        tick(1);
        `CHK(d0o, 16'h1234)
        `CHK(d1o, 16'h5678)
        for (int i = 0; i < 6; i++) begin
            pulse(12'h001 << i);
            rreg(8'ha5, 8'h01 << i);
            wreg(8'ha0, 8'h04);
            rreg(8'ha5, 8'h00);
        end
        `CHK(d0o, 16'hffff)
        `CHK(d1o, 16'hffff)
    endtask

    task automatic t_primary();
        logic [7:0] m [4];
        m = '{8'h01, 8'h02, 8'h08, 8'h20};
        for (int i = 0; i < 4; i++) begin
            pulse(12'h040 << i);
            rreg(8'ha0, m[i]);
            wreg(8'ha0, m[i]);
            rreg(8'ha0, 8'h00);
        end
        fthr = 1'b1;
        tick(2);
        rreg(8'ha0, 8'h10);
        wreg(8'ha0, 8'h10);
        rreg(8'ha0, 8'h10);
        fthr = 1'b0;
        tick(2);
        rreg(8'ha0, 8'h00);
    endtask

    task automatic t_irq();
        pulse(12'h001);
        wreg(8'ha8, 8'hfb);
        tick(2);
        rreg(8'haa, 8'h00);
        `CHK(int_line, 1'b1)
        wreg(8'ha8, 8'h04);
        tick(2);
        rreg(8'haa, 8'h04);
        `CHK(int_line, 1'b0)
        wreg(8'ha0, 8'h04);
        tick(2);
        rreg(8'haa, 8'h00);
        `CHK(int_line, 1'b1)
        wreg(8'ha8, 8'h00);
    endtask

    task automatic t_mid_reset();
        pulse(12'h040);
        wreg(8'ha8, 8'h01);
        tick(1);
        `CHK(int_line, 1'b0)
        rstn = 1'b0;
        tick(1);
        `CHK(int_line, 1'b1)
        tick(3);
        rstn = 1'b1;
        tick(4);
        rreg(8'ha0, 8'h00);
        rreg(8'ha8, 8'h00);
        `CHK(int_line, 1'b1)
    endtask

    task automatic t_secondary();
        wreg(8'ha9, 8'h02);
        pulse(12'h010);
        rreg(8'ha1, 8'h00);
        pulse(12'h008);
        tick(2);
        rreg(8'hab, 8'h04);
        `CHK(int_line, 1'b0)
        wreg(8'ha1, 8'h02);
        rreg(8'ha1, 8'h04);
        wreg(8'ha1, 8'h04);
        rreg(8'ha1, 8'h00);
        wreg(8'ha9, 8'h04);
        pulse(12'h010);
        tick(2);
        rreg(8'hab, 8'h02);
        wreg(8'ha1, 8'h02);
        wreg(8'ha9, 8'h01);
        pulse(12'h800);
        rreg(8'ha1, 8'h00);
        pulse(12'h400);
        tick(2);
        rreg(8'hab, 8'h01);
        wreg(8'ha1, 8'h01);
        pol = 1'b1;
        cor = 1'b1;
        pulse(12'h800);
        wreg(8'ha1, 8'h01);
        rreg(8'ha1, 8'h01);
        rreg(8'ha1, 8'h00);
        cor = 1'b0;
        wreg(8'ha9, 8'h00);
        tick(2);
        `CHK(int_line, 1'b1)
    endtask

    // ----------------------------------------
    // Sequence and watchdog
    // ----------------------------------------
    initial begin
        tick(16);
        rstn = 1'b1;
        tick(4);
        t_reset();
        t_clip_led();
        t_light();
        t_primary();
        t_irq();
        t_secondary();
        t_mid_reset();
        tally_and_finish();
    end

    initial begin
        #(5000 * 100);
        error_cnt++;
        tally_and_finish();
    end
endmodule

`default_nettype wire
